// ==== hdl/ferx_defs.svh ====
`ifndef FERX_DEFS_SVH
`define FERX_DEFS_SVH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define FERX_CLK_MHZ      100
`define FERX_HOLD_US      722
`define FERX_HOLD_CYC     (`FERX_HOLD_US * `FERX_CLK_MHZ)
`define FERX_LINK_US      395
`define FERX_LINK_CYC     (`FERX_LINK_US * `FERX_CLK_MHZ)
`define FERX_SDQ_NS       1000
`define FERX_SDQ_CYC      ((`FERX_SDQ_NS * `FERX_CLK_MHZ + 999) / 1000)

// ----------------------------------------
// line coding
// ----------------------------------------
`define FERX_GRP_W        5
`define FERX_GRP_LAST     3'd4
`define FERX_LFSR_W       11
`define FERX_LFSR_TAP     8
`define FERX_ACQ_BITS     7'd60
`define FERX_HOLD_BITS    6'd58
`define FERX_SSD_ONES     7'd12
`define FERX_END_ONES     7'd10
`define FERX_SSD_TAIL     3'd6
`define FERX_CODE_I       5'h1f
`define FERX_CODE_J       5'h18
`define FERX_CODE_K       5'h11
`define FERX_CODE_T       5'h0d
`define FERX_CODE_R       5'h07
`define FERX_NIB_PRE      4'h5
`define FERX_NIB_BAD      4'he
`define FERX_NIB_ZERO     4'h0
`define FERX_FCC_W        16

`endif

// ==== hdl/ferx_pkg.sv ====
`default_nettype none
package ferx_pkg;

	// one received line symbol
	typedef struct packed {
		logic       vld;
		logic [1:0] level;
	} ferx_line_t;

	// mii receive group toward the mac
	typedef struct packed {
		logic       dv;
		logic       er;
		logic       crs;
		logic [3:0] rxd;
	} ferx_mii_rx_t;

	// receive pcs states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SSD  = 4'b0010,
		ST_DATA = 4'b0100,
		ST_BAD  = 4'b1000
	} ferx_state_t;

endpackage
`default_nettype wire

// ==== hdl/ferx_descrambler.sv ====
`include "ferx_defs.svh"
`default_nettype none
module ferx_descrambler #(
	parameter int HOLD_CYC = `FERX_HOLD_CYC
) (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic bit_vld,
	input  wire logic sd_bit,
	input  wire logic bypass,
	input  wire logic enable,
	output logic      ud_vld,
	output logic      ud_bit,
	output logic      synced
);
	import ferx_pkg::*;

	localparam int TW = $clog2(HOLD_CYC + 1);

	logic [`FERX_LFSR_W-1:0] lfsr_r, lfsr_nxt;
	logic [6:0]              acq_r, acq_nxt;
	logic [5:0]              run_r, run_nxt;
	logic [TW-1:0]           tmr_r, tmr_nxt;
	logic                    sync_r, sync_nxt;
	logic                    udv_r, udv_nxt;
	logic                    ud_r, ud_nxt;
	logic                    pred;
	logic                    plain;

	// ----------------------------------------
	// lfsr, acquisition and hold timer
	// ----------------------------------------
	always_comb begin
		pred     = lfsr_r[`FERX_LFSR_W-1] ^ lfsr_r[`FERX_LFSR_TAP];
		plain    = sd_bit ^ pred;
		lfsr_nxt = lfsr_r;
		acq_nxt  = acq_r;
		run_nxt  = run_r;
		tmr_nxt  = tmr_r;
		sync_nxt = sync_r;
		udv_nxt  = 1'b0;
		ud_nxt   = ud_r;
		if (!enable) begin
			sync_nxt = 1'b0;
			acq_nxt  = 7'h00;
		end else if (bit_vld) begin
			udv_nxt = 1'b1;
			if (bypass) begin
				ud_nxt = sd_bit;
			end else if (!sync_r) begin
				// open loop: idle means keystream is the inverted line bit
				lfsr_nxt = {lfsr_r[`FERX_LFSR_W-2:0], ~sd_bit};
				acq_nxt  = plain ? acq_r + 7'h01 : 7'h00;
				ud_nxt   = 1'b0;
				udv_nxt  = 1'b0;
				if (plain && acq_r == `FERX_ACQ_BITS - 7'h01) begin
					sync_nxt = 1'b1;
					tmr_nxt  = TW'(HOLD_CYC);
					run_nxt  = 6'h00;
				end
			end else begin
				lfsr_nxt = {lfsr_r[`FERX_LFSR_W-2:0], pred};
				ud_nxt   = plain;
				// run restarts after each reload, so a long idle stretch keeps refreshing the timer
				run_nxt  = (plain && run_r != `FERX_HOLD_BITS - 6'h01) ? run_r + 6'h01 : 6'h00;
			end
		end
		// hold timer runs on clock time, not bit time
		if (enable && !bypass && sync_r) begin
			if (bit_vld && plain && run_r == `FERX_HOLD_BITS - 6'h01) begin
				tmr_nxt = TW'(HOLD_CYC);
			end else if (tmr_r == '0) begin
				sync_nxt = 1'b0;
				acq_nxt  = 7'h00;
				udv_nxt  = 1'b0;
			end else begin
				tmr_nxt = tmr_r - TW'(1);
			end
		end
	end

	// state registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lfsr_r <= '0;
			acq_r  <= 7'h00;
			run_r  <= 6'h00;
			tmr_r  <= '0;
			sync_r <= 1'b0;
			udv_r  <= 1'b0;
			ud_r   <= 1'b0;
		end else begin
			lfsr_r <= lfsr_nxt;
			acq_r  <= acq_nxt;
			run_r  <= run_nxt;
			tmr_r  <= tmr_nxt;
			sync_r <= sync_nxt;
			udv_r  <= udv_nxt;
			ud_r   <= ud_nxt;
		end
	end

	assign ud_vld = udv_r;
	assign ud_bit = ud_r;
	assign synced = bypass | sync_r;
endmodule
`default_nettype wire

// ==== hdl/ferx_rx_pcs.sv ====
`include "ferx_defs.svh"
`default_nettype none
module ferx_rx_pcs #(
	parameter int HOLD_CYC = `FERX_HOLD_CYC,
	parameter int LINK_CYC = `FERX_LINK_CYC,
	parameter int SDQ_CYC  = `FERX_SDQ_CYC
) (
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  wire ferx_pkg::ferx_line_t   line_in,
	input  wire logic                   energy_det,
	input  wire logic                   scr_bypass,
	output ferx_pkg::ferx_mii_rx_t      mii_rx,
	output logic                        nib_stb,
	output logic                        link_up,
	output logic                        tx_pcs_en,
	output logic                        rx_synced,
	output logic [`FERX_FCC_W-1:0]      false_carrier_count_reg
);
	import ferx_pkg::*;

	localparam int LW = $clog2(LINK_CYC + 1);
	localparam int QW = $clog2(SDQ_CYC + 1);

	// 5b to 4b lookup: {invalid, nibble}
	function automatic logic [4:0] dec5(input logic [4:0] g);
		logic [4:0] r;
		r = {1'b1, `FERX_NIB_ZERO};
		case (g)
			5'h1e: r = 5'h00;
			5'h09: r = 5'h01;
			5'h14: r = 5'h02;
			5'h15: r = 5'h03;
			5'h0a: r = 5'h04;
			5'h0b: r = 5'h05;
			5'h0e: r = 5'h06;
			5'h0f: r = 5'h07;
			5'h12: r = 5'h08;
			5'h13: r = 5'h09;
			5'h16: r = 5'h0a;
			5'h17: r = 5'h0b;
			5'h1a: r = 5'h0c;
			5'h1b: r = 5'h0d;
			5'h1c: r = 5'h0e;
			5'h1d: r = 5'h0f;
			default: r = {1'b1, `FERX_NIB_ZERO};
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// signal detect and link monitor
	// ----------------------------------------
	logic [QW-1:0] sdq_r, sdq_nxt;
	logic [LW-1:0] lnk_r, lnk_nxt;
	logic          sd_r, sd_nxt;
	logic          up_r, up_nxt;

	// energy must persist far longer than any link pulse
	always_comb begin
		sdq_nxt = sdq_r;
		sd_nxt  = sd_r;
		lnk_nxt = lnk_r;
		up_nxt  = up_r;
		if (!energy_det) begin
			sdq_nxt = '0;
			sd_nxt  = 1'b0;
		end else if (sdq_r == QW'(SDQ_CYC)) begin
			sd_nxt = 1'b1;
		end else begin
			sdq_nxt = sdq_r + QW'(1);
		end
		if (!sd_r) begin
			lnk_nxt = '0;
			up_nxt  = 1'b0;
		end else if (lnk_r == LW'(LINK_CYC)) begin
			up_nxt = 1'b1;
		end else begin
			lnk_nxt = lnk_r + LW'(1);
		end
	end

	// detect and link registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sdq_r <= '0;
			sd_r  <= 1'b0;
			lnk_r <= '0;
			up_r  <= 1'b0;
		end else begin
			sdq_r <= sdq_nxt;
			sd_r  <= sd_nxt;
			lnk_r <= lnk_nxt;
			up_r  <= up_nxt;
		end
	end

	// ----------------------------------------
	// mlt-3 to nrzi to nrz
	// ----------------------------------------
	logic [1:0] lvl_r, lvl_nxt;
	logic       nrzi_r, nrzi_nxt;
	logic       nrz_r, nrz_nxt;
	logic       nrzv_r, nrzv_nxt;

	// a level change toggles nrzi; an nrzi edge is a one
	always_comb begin
		lvl_nxt  = lvl_r;
		nrzi_nxt = nrzi_r;
		nrz_nxt  = nrz_r;
		nrzv_nxt = line_in.vld;
		if (line_in.vld) begin
			lvl_nxt  = line_in.level;
			nrzi_nxt = nrzi_r ^ (line_in.level != lvl_r);
			nrz_nxt  = nrzi_nxt ^ nrzi_r;
		end
	end

	// line conversion registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			lvl_r  <= 2'h0;
			nrzi_r <= 1'b0;
			nrz_r  <= 1'b0;
			nrzv_r <= 1'b0;
		end else begin
			lvl_r  <= lvl_nxt;
			nrzi_r <= nrzi_nxt;
			nrz_r  <= nrz_nxt;
			nrzv_r <= nrzv_nxt;
		end
	end

	// ----------------------------------------
	// descrambler
	// ----------------------------------------
	logic ud_vld;
	logic ud_bit;
	logic synced;
	logic pcs_en;

	ferx_descrambler #(
		.HOLD_CYC (HOLD_CYC)
	) u_descr (
		.clk     (clk),
		.reset_n (reset_n),
		.bit_vld (nrzv_r),
		.sd_bit  (nrz_r),
		.bypass  (scr_bypass),
		.enable  (up_r),
		.ud_vld  (ud_vld),
		.ud_bit  (ud_bit),
		.synced  (synced)
	);

	assign pcs_en = up_r & synced;

	// ----------------------------------------
	// alignment and receive state machine
	// ----------------------------------------
	ferx_state_t st_r, st_nxt;
	logic [14:0] win_r, win_nxt;
	logic [6:0]  ones_r, ones_nxt;
	logic [2:0]  ph_r, ph_nxt;
	logic [2:0]  tail_r, tail_nxt;
	logic [4:0]  prev_r, prev_nxt;
	logic        pvld_r, pvld_nxt;
	logic        prek_r, prek_nxt;
	logic [`FERX_FCC_W-1:0] fcc_r, fcc_nxt;
	logic        ostb;
	logic        oer;
	logic [3:0]  onib;
	logic        grp_done;
	logic [4:0]  cur;
	logic [4:0]  dprev;

	// one bit per step; groups complete every fifth bit
	always_comb begin
		st_nxt   = st_r;
		win_nxt  = win_r;
		ones_nxt = ones_r;
		ph_nxt   = ph_r;
		tail_nxt = tail_r;
		prev_nxt = prev_r;
		pvld_nxt = pvld_r;
		prek_nxt = prek_r;
		fcc_nxt  = fcc_r;
		ostb     = 1'b0;
		oer      = 1'b0;
		onib     = `FERX_NIB_ZERO;
		grp_done = 1'b0;
		cur      = win_r[4:0];
		dprev    = dec5(prev_r);
		if (!pcs_en) begin
			st_nxt   = ST_IDLE;
			ones_nxt = 7'h00;
			pvld_nxt = 1'b0;
			prek_nxt = 1'b0;
		end else if (ud_vld) begin
			win_nxt  = {win_r[13:0], ud_bit};
			cur      = win_nxt[4:0];
			ones_nxt = ud_bit ? ((ones_r == 7'h7f) ? ones_r : ones_r + 7'h01) : 7'h00;
			grp_done = (ph_r == `FERX_GRP_LAST);
			ph_nxt   = grp_done ? 3'h0 : ph_r + 3'h1;
			case (st_r)
				ST_IDLE: begin
					// first zero after idles: j has two ones before it
					if (!ud_bit && ones_r >= `FERX_SSD_ONES) begin
						st_nxt   = ST_SSD;
						tail_nxt = 3'h0;
					end
				end
				ST_SSD: begin
					tail_nxt = tail_r + 3'h1;
					if (tail_r == `FERX_SSD_TAIL) begin
						if (win_nxt[9:0] == {`FERX_CODE_J, `FERX_CODE_K}) begin
							st_nxt   = ST_DATA;
							ph_nxt   = 3'h0;
							ostb     = 1'b1;
							onib     = `FERX_NIB_PRE;
							prek_nxt = 1'b1;
							pvld_nxt = 1'b0;
						end else begin
							st_nxt  = ST_BAD;
							ph_nxt  = 3'h0;
							fcc_nxt = fcc_r + `FERX_FCC_W'(1);
							ostb    = 1'b1;
							oer     = 1'b1;
							onib    = `FERX_NIB_BAD;
						end
					end
				end
				ST_DATA: begin
					if (grp_done) begin
						if (pvld_r && prev_r == `FERX_CODE_T && cur == `FERX_CODE_R) begin
							st_nxt   = ST_IDLE;
							pvld_nxt = 1'b0;
						end else if (pvld_r && prev_r == `FERX_CODE_I && cur == `FERX_CODE_I) begin
							st_nxt   = ST_IDLE;
							pvld_nxt = 1'b0;
						end else begin
							// output lags one group so a t can wait for its r
							ostb     = prek_r | pvld_r;
							onib     = prek_r ? `FERX_NIB_PRE : dprev[3:0];
							oer      = !prek_r & dprev[4];
							prek_nxt = 1'b0;
							prev_nxt = cur;
							pvld_nxt = 1'b1;
						end
					end
				end
				ST_BAD: begin
					if (ones_nxt >= `FERX_END_ONES) begin
						st_nxt = ST_IDLE;
					end else if (grp_done) begin
						ostb = 1'b1;
						oer  = 1'b1;
						onib = `FERX_NIB_BAD;
					end
				end
				default: begin
					st_nxt = ST_IDLE;
				end
			endcase
		end
	end

	// receive state registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r   <= ST_IDLE;
			win_r  <= 15'h0000;
			ones_r <= 7'h00;
			ph_r   <= 3'h0;
			tail_r <= 3'h0;
			prev_r <= 5'h00;
			pvld_r <= 1'b0;
			prek_r <= 1'b0;
			fcc_r  <= '0;
		end else begin
			st_r   <= st_nxt;
			win_r  <= win_nxt;
			ones_r <= ones_nxt;
			ph_r   <= ph_nxt;
			tail_r <= tail_nxt;
			prev_r <= prev_nxt;
			pvld_r <= pvld_nxt;
			prek_r <= prek_nxt;
			fcc_r  <= fcc_nxt;
		end
	end

	// ----------------------------------------
	// mii receive outputs
	// ----------------------------------------
	ferx_mii_rx_t mii_r, mii_nxt;
	logic         stb_r, stb_nxt;

	// nibble and error hold between strobes; dv and crs follow state
	always_comb begin
		mii_nxt     = mii_r;
		stb_nxt     = ostb;
		mii_nxt.dv  = pcs_en & (st_nxt == ST_DATA);
		mii_nxt.crs = pcs_en & (st_nxt != ST_IDLE);
		if (ostb) begin
			mii_nxt.rxd = onib;
			mii_nxt.er  = oer;
		end
		if (!mii_nxt.crs) begin
			mii_nxt.er  = 1'b0;
			mii_nxt.rxd = `FERX_NIB_ZERO;
		end
	end

	// output registers
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mii_r <= '0;
			stb_r <= 1'b0;
		end else begin
			mii_r <= mii_nxt;
			stb_r <= stb_nxt;
		end
	end

	assign mii_rx                  = mii_r;
	assign nib_stb                 = stb_r;
	assign link_up                 = up_r;
	assign tx_pcs_en               = up_r;
	assign rx_synced               = synced;
	assign false_carrier_count_reg = fcc_r;
endmodule
`default_nettype wire

// ==== testbench/ferx_rx_pcs_monitor.sv ====
`include "ferx_defs.svh"
`default_nettype none
module ferx_rx_pcs_monitor #(
	parameter int HOLD_CYC = 2000,
	parameter int LINK_CYC = 50,
	parameter int SDQ_CYC  = 20
) (
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire logic                   energy_det,
	input wire logic                   scr_bypass,
	input wire ferx_pkg::ferx_mii_rx_t mii_rx,
	input wire logic                   nib_stb,
	input wire logic                   link_up,
	input wire logic                   tx_pcs_en,
	input wire logic                   rx_synced,
	input wire logic [`FERX_FCC_W-1:0] false_carrier_count_reg
);
	import ferx_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	int en_run;

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	// unbroken energy run, so a glitch restarts link qualification
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			en_run <= 0;
		end else begin
			en_run <= energy_det ? en_run + 1 : 0;
		end
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	property p_link_time;
		$rose(link_up) |-> en_run >= SDQ_CYC + LINK_CYC;
	endproperty
	a_link_time: assert property (p_link_time) else $error("link up too early");
	property p_tx_en;
		tx_pcs_en == link_up;
	endproperty
	a_tx_en: assert property (p_tx_en) else $error("tx pcs enable differs from link");
	property p_off;
		(!link_up || !rx_synced) [*2] |-> !mii_rx.dv && !mii_rx.crs;
	endproperty
	a_off: assert property (p_off) else $error("carrier without link or sync");
	property p_dv_crs;
		mii_rx.dv |-> mii_rx.crs;
	endproperty
	a_dv_crs: assert property (p_dv_crs) else $error("dv without crs");
	property p_stb_gap;
		nib_stb |=> !nib_stb [*4];
	endproperty
	a_stb_gap: assert property (p_stb_gap) else $error("nibble strobes too close");
	property p_fcc;
		$changed(false_carrier_count_reg) |-> false_carrier_count_reg == $past(false_carrier_count_reg) + 16'h1;
	endproperty
	a_fcc: assert property (p_fcc) else $error("false carrier count jump");
	property p_bad;
		nib_stb && mii_rx.crs && !mii_rx.dv |-> mii_rx.er && mii_rx.rxd == 4'he;
	endproperty
	a_bad: assert property (p_bad) else $error("bad start nibble wrong");
	property p_data_err;
		nib_stb && mii_rx.dv && mii_rx.er |-> mii_rx.rxd == 4'h0;
	endproperty
	a_data_err: assert property (p_data_err) else $error("invalid group nibble wrong");
	property p_quiet;
		!mii_rx.crs |-> !mii_rx.er && mii_rx.rxd == 4'h0;
	endproperty
	a_quiet: assert property (p_quiet) else $error("error without carrier");
	property p_bypass;
		scr_bypass |-> rx_synced;
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass not synced");
endmodule
`default_nettype wire

// ==== testbench/ferx_mac_model.sv ====
`default_nettype none
module ferx_mac_model (
	input wire logic                   clk,
	input wire logic                   reset_n,
	input wire ferx_pkg::ferx_mii_rx_t mii_rx,
	input wire logic                   nib_stb,
	output logic [31:0]                nibs,
	output logic [7:0]                 n_cnt,
	output logic [7:0]                 er_cnt
);
	import ferx_pkg::*;
	// mac side: keeps the last eight nibbles, counts strobes and errors
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			nibs   <= '0;
			n_cnt  <= '0;
			er_cnt <= '0;
		end else if (nib_stb) begin
			nibs  <= {nibs[27:0], mii_rx.rxd};
			n_cnt <= n_cnt + 8'h1;
			if (mii_rx.er) begin
				er_cnt <= er_cnt + 8'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ==== testbench/test_fast_ethernet_rx_pcs.sv ====
`include "ferx_defs.svh"
`default_nettype none
`define TB_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
	$display("Error %s exp %0h got %0h", nm, e, g); end end
module test_fast_ethernet_rx_pcs;
	timeunit 1ns;
	timeprecision 1ps;
	import ferx_pkg::*;
	localparam int HOLD = 2000;
	localparam int LINK = 50;
	localparam int SDQ  = 20;
	localparam logic [4:0] D0 = 5'h1e;
	localparam logic [4:0] D5 = 5'h0b;
	localparam logic [4:0] DA = 5'h16;
	localparam logic [4:0] DF = 5'h1d;
	logic                   clk, reset_n, energy_det, scr_bypass;
	logic                   nib_stb, link_up, tx_pcs_en, rx_synced;
	ferx_line_t             line_in;
	ferx_mii_rx_t           mii_rx;
	logic [`FERX_FCC_W-1:0] false_carrier_count_reg;
	logic [31:0]            nibs;
	logic [7:0]             n_cnt, er_cnt;
	logic [10:0]            ks;
	logic [1:0]             ph;
	int                     bad_count, tests_run;

	ferx_rx_pcs #(.HOLD_CYC(HOLD), .LINK_CYC(LINK), .SDQ_CYC(SDQ)) u_ferx_rx_pcs (.clk(clk),
		.reset_n(reset_n), .line_in(line_in), .energy_det(energy_det), .scr_bypass(scr_bypass),
		.mii_rx(mii_rx), .nib_stb(nib_stb), .link_up(link_up), .tx_pcs_en(tx_pcs_en),
		.rx_synced(rx_synced), .false_carrier_count_reg(false_carrier_count_reg));
	ferx_mac_model u_ferx_mac_model (.clk(clk), .reset_n(reset_n), .mii_rx(mii_rx),
		.nib_stb(nib_stb), .nibs(nibs), .n_cnt(n_cnt), .er_cnt(er_cnt));

	// ----------------------------------------
	// line driver
	// ----------------------------------------
	// scramble, nrzi and mlt-3 in one step; keystream runs even in bypass
	task automatic tx_bit(input logic b);
		logic n;
		n = ks[10] ^ ks[8];
		ks = {ks[9:0], n};
		@(negedge clk);
		if (scr_bypass ? b : b ^ n) begin
			ph = ph + 2'd1;
		end
		line_in.vld = 1'b1;
		line_in.level = (ph == 2'd3) ? 2'd1 : ph;
	endtask
	// groups go out msb first
	task automatic tx_grp(input logic [4:0] g, input int n);
		for (int k = 0; k < n; k++) begin
			for (int i = 4; i >= 0; i--) begin
				tx_bit(g[i]);
			end
		end
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// short pulse must not qualify, a steady one must after the full time
	task automatic link_test();
		int cnt;
		@(negedge clk);
		energy_det = 1'b1;
		repeat (10) @(negedge clk);
		energy_det = 1'b0;
		repeat (40) @(negedge clk);
		`TB_CHK("link_short", 1'b0, link_up)
		energy_det = 1'b1;
		cnt = 0;
		while (link_up !== 1'b1 && cnt < 300) begin
			@(negedge clk);
			cnt++;
		end
		`TB_CHK("link_time", 1'b1, (cnt >= SDQ + LINK) && (cnt <= SDQ + LINK + 6))
		`TB_CHK("tx_en", 1'b1, tx_pcs_en)
		`TB_CHK("no_sync", 1'b0, rx_synced)
	endtask
	// frame j k a mid 0, ended by t r or by idles only
	task automatic frame(input logic [4:0] mid, input logic [19:0] exp, input logic [7:0] er_add, input logic tr);
		logic [7:0] n0;
		logic [7:0] e0;
		n0 = n_cnt;
		e0 = er_cnt;
		tx_grp(`FERX_CODE_I, 14);
		tx_grp(`FERX_CODE_J, 1);
		tx_grp(`FERX_CODE_K, 1);
		tx_grp(DA, 1);
		tx_grp(mid, 1);
		tx_grp(D0, 1);
		if (tr) begin
			tx_grp(`FERX_CODE_T, 1);
			tx_grp(`FERX_CODE_R, 1);
		end
		tx_grp(`FERX_CODE_I, 4);
		`TB_CHK("nibbles", exp, nibs[19:0])
		`TB_CHK("count", 8'd5, 8'(n_cnt - n0))
		`TB_CHK("errors", er_add, 8'(er_cnt - e0))
		`TB_CHK("dv_end", 1'b0, mii_rx.dv)
	endtask
	// acquisition, then hold timer refresh and expiry
	task automatic sync_test();
		int lost;
		tx_grp(`FERX_CODE_I, 16);
		`TB_CHK("sync", 1'b1, rx_synced)
		frame(DF, 20'h55af0, 8'h0, 1'b1);
		// sync must never drop while idles keep coming, not just at the end
		lost = 0;
		for (int g = 0; g < 2 * HOLD / 5; g++) begin
			tx_grp(`FERX_CODE_I, 1);
			lost += (rx_synced !== 1'b1);
		end
		`TB_CHK("sync_kept", 0, lost)
		tx_grp(D0, (HOLD - 100) / 5);
		`TB_CHK("sync_hold", 1'b1, rx_synced)
		tx_grp(D0, 120);
		`TB_CHK("sync_lost", 1'b0, rx_synced)
		tx_grp(`FERX_CODE_I, 16);
		`TB_CHK("resync", 1'b1, rx_synced)
	endtask
	// idles straight into data with no j k
	task automatic bad_start();
		logic [`FERX_FCC_W-1:0] f0;
		f0 = false_carrier_count_reg;
		tx_grp(`FERX_CODE_I, 14);
		tx_grp(D5, 2);
		tx_grp(`FERX_CODE_I, 4);
		`TB_CHK("fcc", 16'(f0 + 16'h1), false_carrier_count_reg)
		`TB_CHK("bad_nib", 4'he, nibs[3:0])
		`TB_CHK("crs_end", 1'b0, mii_rx.crs)
	endtask

	// ----------------------------------------
	// run control
	// ----------------------------------------
	task automatic finish_test();
		$display("tests %0d errors %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// free running 100 mhz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// cut a hang well past the expected run length
	initial begin
		#300000;
		bad_count++;
		finish_test();
	end
	// main sequence: scrambled first, so the descrambler starts clean
	initial begin
		line_in = '0;
		energy_det = 1'b0;
		scr_bypass = 1'b0;
		reset_n = 1'b0;
		ks = 11'h5a5;
		ph = 2'd0;
		bad_count = 0;
		tests_run = 0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		link_test();
		sync_test();
		scr_bypass = 1'b1;
		tx_grp(`FERX_CODE_I, 4); // drain scrambled bits still in the pipe
		frame(DF, 20'h55af0, 8'h0, 1'b1);
		frame(`FERX_CODE_J, 20'h55a00, 8'h1, 1'b1);
		frame(DF, 20'h55af0, 8'h0, 1'b0);
		bad_start();
		finish_test();
	end
endmodule
bind ferx_rx_pcs ferx_rx_pcs_monitor #(.HOLD_CYC(HOLD_CYC), .LINK_CYC(LINK_CYC), .SDQ_CYC(SDQ_CYC))
	u_ferx_rx_pcs_monitor (.clk(clk), .reset_n(reset_n), .energy_det(energy_det),
	.scr_bypass(scr_bypass), .mii_rx(mii_rx), .nib_stb(nib_stb), .link_up(link_up),
	.tx_pcs_en(tx_pcs_en), .rx_synced(rx_synced), .false_carrier_count_reg(false_carrier_count_reg));
`default_nettype wire
